// *** src/lcd_pkg.sv ***
package lcd_pkg;
  // System clock and two-wire bit rate
  localparam int CLK_HZ = 10_000_000;
  localparam int SCL_HZ = 100_000;
  localparam int SCL_QTR_CYC = CLK_HZ / (4 * SCL_HZ);
  localparam logic [7:0] SCL_QTR_LAST = 8'(SCL_QTR_CYC - 1);

  // Slave address: fixed upper five bits, two strap bits below
  localparam logic [4:0] SLAVE_ADDR_BASE = 5'h0F;

  // Control byte layout
  localparam int CTRL_CONT_BIT = 7;
  localparam int CTRL_DC_BIT = 6;

  // Display data RAM
  localparam int DISPLAY_DATA_RAM_DEPTH = 80;
  localparam logic [6:0] DISPLAY_DATA_RAM_LAST = 7'h4F;
  localparam logic [6:0] DISPLAY_DATA_RAM_FIRST = 7'h00;
  localparam logic [7:0] BLANK_CHAR = 8'h20;

  // Settings bundle bit positions
  localparam int SET_FONT = 0;
  localparam int SET_LINES = 1;
  localparam int SET_BUS_LEN = 2;
  localparam int SET_BLINK = 3;
  localparam int SET_CURSOR = 4;
  localparam int SET_DISPLAY = 5;
  localparam int SET_SHIFT = 6;
  localparam int SET_INCR = 7;
  // Bus length 1, increment 1, all else 0
  localparam logic [7:0] SETTINGS_RST = 8'h84;

  // Controller register map (byte offsets)
  localparam logic [3:0] REG_TXDATA = 4'h0;
  localparam logic [3:0] REG_CMD = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_TARGET = 4'h8;
  localparam logic [6:0] TARGET_RST = 7'h3C;
  localparam int CMD_WRITE = 0;
  localparam int CMD_READ = 1;
  localparam int CMD_DC = 2;
  localparam int FIFO_W = 8;
  localparam int FIFO_DEPTH = 32;

  // Byte sequence inside a controller frame
  localparam logic [1:0] SEQ_ADDR = 2'h0;
  localparam logic [1:0] SEQ_CTRL = 2'h1;
  localparam logic [1:0] SEQ_DATA = 2'h2;
  localparam logic [1:0] SEQ_RX = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ADDR_ACK = 3'h3,
    ST_BYTE = 3'h2,
    ST_BYTE_ACK = 3'h6,
    ST_TX = 3'h7,
    ST_TX_ACK = 3'h5,
    ST_IGNORE = 3'h4
  } dev_state_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_START = 3'h1,
    H_BITS = 3'h3,
    H_ACK = 3'h2,
    H_STOP = 3'h6
  } host_state_t;
endpackage : lcd_pkg

// *** src/lcd_link_if.sv ***
`timescale 1ns/1ps
interface lcd_link_if;
  logic scl_o;
  logic scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic chip_select_n;
  logic scl;
  logic sda;

  // Open-drain wires with pull-ups: any enabled low driver wins
  assign scl = scl_oe_n | scl_o;
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

  modport device (input scl, input sda, input chip_select_n, output dev_sda_o,
    output dev_sda_oe_n);
  modport host (input scl, input sda, output scl_o, output scl_oe_n, output host_sda_o,
    output host_sda_oe_n, output chip_select_n);
endinterface : lcd_link_if

// *** src/lcd_dev.sv ***
`timescale 1ns/1ps
// Summary of operation
// RL1 - Answer only addresses 0111100 to 0111111
// RL2 - Two low address bits come from straps
// RL3 - START then address; ack match, else ignore
// RL4 - Command word: control byte then data byte
// RL5 - Cleared continuation flag: only data follows
// RL6 - Selector 1: store byte in RAM, advance
// RL7 - Selector 0: decode byte as instruction
// RL8 - Acknowledge every control and data byte
// RL9 - Master ends each transmission with STOP
// RL10 - Master nack stops device data output
// RL11 - Busy high until power-up init completes
// RL12 - Init fills display RAM with 20H
// RL13 - Reset: 8-bit length, one line, 5x8
// RL14 - Reset: display, cursor and blink off
// RL15 - Reset: increment by one, no shift
// RL16 - Host initialises by instructions if needed
// RL17 - Host keeps length 1, select low
// RL18 - Busy high during internal operations
// RL19 - START or STOP discards parsing state
module lcd_dev (
  input wire logic clk, // System clock
  input wire logic reset, // Synchronous reset, active high
  lcd_link_if.device link, // Two-wire link
  input wire logic addr_strap_lo, // Address bit 0 strap
  input wire logic addr_strap_hi, // Address bit 1 strap
  output logic busy_indication, // High while an internal operation runs
  output logic [7:0] settings, // Display settings bundle
  output logic [6:0] addr_counter, // Display RAM data pointer
  input wire logic [6:0] disp_rd_addr, // Display scan read address
  output logic [7:0] disp_rd_data // Display scan read data, one cycle late
);
  import lcd_pkg::*;

  dev_state_t state_reg;
  logic scl_q_reg;
  logic sda_q_reg;
  logic strap_lo_reg;
  logic strap_hi_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic done_reg;
  logic rw_reg;
  logic sda_oe_n_reg;
  logic byte_stb_reg;
  logic [7:0] byte_data_reg;
  logic expect_ctrl_reg;
  logic cont_reg;
  logic dc_reg;
  logic wr_stb_reg;
  logic cmd_stb_reg;
  logic [7:0] payload_reg;
  logic busy_reg;
  logic [6:0] fill_addr_reg;
  logic [6:0] addr_reg;
  logic [7:0] settings_reg;
  logic [7:0] rd_data_reg;
  logic [7:0] ram [DISPLAY_DATA_RAM_DEPTH];
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;
  logic [7:0] status_byte;

  // Next pointer value, wrapping inside the populated RAM range
  function automatic logic [6:0] step_addr(input logic [6:0] a, input logic up);
    logic [6:0] r;
    r = a;
    if (up) begin
      r = (a == DISPLAY_DATA_RAM_LAST) ? DISPLAY_DATA_RAM_FIRST : a + 7'h01;
    end else begin
      r = (a == DISPLAY_DATA_RAM_FIRST) ? DISPLAY_DATA_RAM_LAST : a - 7'h01;
    end
    return r;
  endfunction : step_addr

  // Previous line levels for edge and condition detection
  always_ff @(posedge clk) begin
    if (reset) begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end else begin
      scl_q_reg <= link.scl;
      sda_q_reg <= link.sda;
    end
  end

  // Straps are static, so sampling every cycle after release is enough
  always_ff @(posedge clk) begin
    if (reset) begin
      strap_lo_reg <= 1'b0;
      strap_hi_reg <= 1'b0;
    end else begin
      strap_lo_reg <= addr_strap_lo; // RL2
      strap_hi_reg <= addr_strap_hi; // RL2
    end
  end

  // START only counts while the chip is selected for the serial link
  assign start_det = link.scl & scl_q_reg & sda_q_reg & ~link.sda & ~link.chip_select_n;
  assign stop_det = link.scl & scl_q_reg & ~sda_q_reg & link.sda;
  assign scl_rise = link.scl & ~scl_q_reg;
  assign scl_fall = ~link.scl & scl_q_reg;
  // Status read returns busy on top of the data pointer
  assign status_byte = {busy_reg, addr_reg};

  // Bit engine: sda only changes after scl falls, so START/STOP stay unambiguous
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'hFF;
      done_reg <= 1'b0;
      rw_reg <= 1'b0;
      sda_oe_n_reg <= 1'b1;
      byte_stb_reg <= 1'b0;
      byte_data_reg <= 8'h00;
    end else begin
      byte_stb_reg <= 1'b0;
      if (stop_det) begin
        state_reg <= ST_IDLE;
        sda_oe_n_reg <= 1'b1;
      end else if (start_det) begin
        state_reg <= ST_ADDR; // RL3
        bit_cnt_reg <= 3'h0;
        done_reg <= 1'b0;
        sda_oe_n_reg <= 1'b1;
      end else begin
        case (state_reg)
          ST_ADDR, ST_BYTE: begin
            if (scl_rise && !done_reg) begin
              shift_reg <= {shift_reg[6:0], link.sda};
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
              done_reg <= (bit_cnt_reg == 3'h7);
            end else if (scl_fall && done_reg) begin
              done_reg <= 1'b0;
              bit_cnt_reg <= 3'h0;
              if (state_reg == ST_BYTE) begin
                byte_stb_reg <= 1'b1;
                byte_data_reg <= shift_reg;
                sda_oe_n_reg <= 1'b0; // RL8
                state_reg <= ST_BYTE_ACK;
              end else if (shift_reg[7:1] == {SLAVE_ADDR_BASE, strap_hi_reg, strap_lo_reg}) begin
                rw_reg <= shift_reg[0]; // RL1
                sda_oe_n_reg <= 1'b0; // RL3
                state_reg <= ST_ADDR_ACK;
              end else begin
                state_reg <= ST_IGNORE; // RL1
              end
            end
          end
          ST_ADDR_ACK: begin
            if (scl_fall) begin
              if (rw_reg) begin
                tx_reg <= status_byte;
                sda_oe_n_reg <= status_byte[7];
                state_reg <= ST_TX;
              end else begin
                sda_oe_n_reg <= 1'b1;
                state_reg <= ST_BYTE;
              end
            end
          end
          ST_BYTE_ACK: begin
            if (scl_fall) begin
              sda_oe_n_reg <= 1'b1;
              state_reg <= ST_BYTE;
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt_reg == 3'h7) begin
                bit_cnt_reg <= 3'h0;
                sda_oe_n_reg <= 1'b1;
                state_reg <= ST_TX_ACK;
              end else begin
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                tx_reg <= {tx_reg[6:0], 1'b1};
                sda_oe_n_reg <= tx_reg[6];
              end
            end
          end
          ST_TX_ACK: begin
            if (scl_rise) begin
              if (link.sda) begin
                state_reg <= ST_IGNORE; // RL10
              end else begin
                done_reg <= 1'b1;
              end
            end else if (scl_fall && done_reg) begin
              done_reg <= 1'b0;
              tx_reg <= status_byte;
              sda_oe_n_reg <= status_byte[7];
              state_reg <= ST_TX;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Control byte parser; a stale command word must not leak into the next frame
  always_ff @(posedge clk) begin
    if (reset) begin
      expect_ctrl_reg <= 1'b1;
      cont_reg <= 1'b1;
      dc_reg <= 1'b0;
      wr_stb_reg <= 1'b0;
      cmd_stb_reg <= 1'b0;
      payload_reg <= 8'h00;
    end else begin
      wr_stb_reg <= 1'b0;
      cmd_stb_reg <= 1'b0;
      if (start_det || stop_det) begin
        expect_ctrl_reg <= 1'b1; // RL19
        cont_reg <= 1'b1;
        dc_reg <= 1'b0;
      end else if (byte_stb_reg) begin
        if (expect_ctrl_reg) begin
          cont_reg <= byte_data_reg[CTRL_CONT_BIT]; // RL4
          dc_reg <= byte_data_reg[CTRL_DC_BIT]; // RL4
          expect_ctrl_reg <= 1'b0;
        end else begin
          expect_ctrl_reg <= cont_reg; // RL5
          wr_stb_reg <= dc_reg; // RL6
          cmd_stb_reg <= ~dc_reg; // RL7
          payload_reg <= byte_data_reg;
        end
      end
    end
  end

  // Executor; bytes arriving while busy are acknowledged but dropped
  always_ff @(posedge clk) begin
    if (reset) begin
      busy_reg <= 1'b1; // RL11
      fill_addr_reg <= DISPLAY_DATA_RAM_FIRST;
      addr_reg <= DISPLAY_DATA_RAM_FIRST;
      settings_reg <= SETTINGS_RST; // RL13 RL14 RL15
    end else if (busy_reg) begin
      if (fill_addr_reg == DISPLAY_DATA_RAM_LAST) begin
        busy_reg <= 1'b0; // RL11 RL18
      end else begin
        fill_addr_reg <= fill_addr_reg + 7'h01;
      end
    end else if (wr_stb_reg) begin
      addr_reg <= step_addr(addr_reg, settings_reg[SET_INCR]); // RL6
    end else if (cmd_stb_reg) begin
      casez (payload_reg) // RL7
        8'b1???????: begin
          addr_reg <= (payload_reg[6:0] > DISPLAY_DATA_RAM_LAST) ? DISPLAY_DATA_RAM_FIRST : payload_reg[6:0];
        end
        8'b001?????: begin
          settings_reg[SET_BUS_LEN] <= payload_reg[4];
          settings_reg[SET_LINES] <= payload_reg[3];
          settings_reg[SET_FONT] <= payload_reg[2];
        end
        8'b0001????: begin
          // Only cursor moves touch the pointer; display shift is not modelled
          if (!payload_reg[3]) begin
            addr_reg <= step_addr(addr_reg, payload_reg[2]);
          end
        end
        8'b00001???: begin
          settings_reg[SET_DISPLAY] <= payload_reg[2];
          settings_reg[SET_CURSOR] <= payload_reg[1];
          settings_reg[SET_BLINK] <= payload_reg[0];
        end
        8'b000001??: begin
          settings_reg[SET_INCR] <= payload_reg[1];
          settings_reg[SET_SHIFT] <= payload_reg[0];
        end
        8'b0000001?: begin
          addr_reg <= DISPLAY_DATA_RAM_FIRST;
        end
        8'b00000001: begin
          busy_reg <= 1'b1; // RL18
          fill_addr_reg <= DISPLAY_DATA_RAM_FIRST;
          addr_reg <= DISPLAY_DATA_RAM_FIRST;
          settings_reg[SET_INCR] <= 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  // Display RAM: fill has priority, writes are dropped while it runs
  always_ff @(posedge clk) begin
    if (busy_reg) begin
      ram[fill_addr_reg] <= BLANK_CHAR; // RL12
    end else if (wr_stb_reg) begin
      ram[addr_reg] <= payload_reg; // RL6
    end
    rd_data_reg <= ram[disp_rd_addr];
  end

  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe_n = sda_oe_n_reg;
  assign busy_indication = busy_reg;
  assign settings = settings_reg;
  assign addr_counter = addr_reg;
  assign disp_rd_data = rd_data_reg;
endmodule : lcd_dev

// *** src/lcd_host.sv ***
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk, // System clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic in_valid, // Write request
  output logic in_ready, // Room for one more word
  input wire logic [WIDTH-1:0] in_data, // Write data
  output logic out_valid, // Word available
  input wire logic out_ready, // Consumer takes the word
  output logic [WIDTH-1:0] out_data // Oldest word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rd_ptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Pointers wrap explicitly so a depth that is not a power of two still works
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        mem[wr_ptr_reg] <= in_data;
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + AW'(1);
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : byte_fifo

module lcd_host (
  input wire logic clk, // System clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic [3:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  lcd_link_if.host link // Two-wire link
);
  import lcd_pkg::*;

  logic wait_reg;
  logic [31:0] rdata_reg;
  logic [6:0] target_reg;
  logic pend_wr_reg;
  logic pend_rd_reg;
  logic pend_dc_reg;
  logic dc_reg;
  logic [7:0] div_reg;
  logic tick_reg;
  host_state_t state_reg;
  logic [1:0] phase_reg;
  logic [2:0] bit_cnt_reg;
  logic [1:0] seq_reg;
  logic [7:0] tx_reg;
  logic [7:0] rx_reg;
  logic nack_reg;
  logic scl_oe_n_reg;
  logic sda_oe_n_reg;
  logic cs_n_reg;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic push;
  logic pop;
  logic ack_end;
  logic engine_busy;
  logic take_wr;
  logic take_rd;

  byte_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) i_byte_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(avs_writedata[7:0]),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out_data)
  );

  assign push = avs_write & ~wait_reg & (avs_address == REG_TXDATA);
  assign engine_busy = (state_reg != H_IDLE) | pend_wr_reg | pend_rd_reg;
  // Request consumed by the frame engine in this cycle; write frames go first
  assign take_wr = tick_reg & (state_reg == H_IDLE) & pend_wr_reg;
  assign take_rd = tick_reg & (state_reg == H_IDLE) & ~pend_wr_reg & pend_rd_reg;
  assign ack_end = tick_reg & (state_reg == H_ACK) & (phase_reg == 2'h3);
  assign pop = ack_end & ~nack_reg & (seq_reg == SEQ_CTRL || seq_reg == SEQ_DATA) & fifo_out_valid;

  // Bus slave: one wait cycle per access; a full FIFO stalls data writes
  always_ff @(posedge clk) begin
    if (reset) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else if (!wait_reg) begin
      wait_reg <= 1'b1;
    end else if (avs_read) begin
      wait_reg <= 1'b0;
      case (avs_address)
        REG_STATUS: rdata_reg <= {16'h0000, rx_reg, 4'h0, ~fifo_in_ready, ~fifo_out_valid,
          nack_reg, engine_busy};
        REG_TARGET: rdata_reg <= {25'h0000000, target_reg};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end else if (avs_write && (avs_address != REG_TXDATA || fifo_in_ready)) begin
      wait_reg <= 1'b0;
    end
  end

  // Target address and frame requests; commands during a frame are queued once
  always_ff @(posedge clk) begin
    if (reset) begin
      target_reg <= TARGET_RST;
      pend_wr_reg <= 1'b0;
      pend_rd_reg <= 1'b0;
      pend_dc_reg <= 1'b0;
    end else begin
      if (avs_write && !wait_reg && avs_address == REG_TARGET) begin
        target_reg <= avs_writedata[6:0];
      end
      // A command written as a frame starts must not cancel that frame's take
      if (avs_write && !wait_reg && avs_address == REG_CMD) begin
        pend_wr_reg <= (pend_wr_reg & ~take_wr) | avs_writedata[CMD_WRITE];
        pend_rd_reg <= (pend_rd_reg & ~take_rd) | avs_writedata[CMD_READ];
        pend_dc_reg <= avs_writedata[CMD_DC];
      end else begin
        pend_wr_reg <= pend_wr_reg & ~take_wr;
        pend_rd_reg <= pend_rd_reg & ~take_rd;
      end
    end
  end

  // Quarter-bit tick divider
  always_ff @(posedge clk) begin
    if (reset) begin
      div_reg <= 8'h00;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (div_reg == SCL_QTR_LAST);
      div_reg <= (div_reg == SCL_QTR_LAST) ? 8'h00 : div_reg + 8'h01;
    end
  end

  // Chip select held low for the serial link
  always_ff @(posedge clk) begin
    cs_n_reg <= 1'b0; // RL17
  end

  // Bit engine: four quarter phases per bit, sda changes only while scl is low except at START and STOP
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= H_IDLE;
      phase_reg <= 2'h0;
      bit_cnt_reg <= 3'h0;
      seq_reg <= SEQ_ADDR;
      tx_reg <= 8'hFF;
      rx_reg <= 8'h00;
      nack_reg <= 1'b0;
      dc_reg <= 1'b0;
      scl_oe_n_reg <= 1'b1;
      sda_oe_n_reg <= 1'b1;
    end else if (tick_reg) begin
      phase_reg <= phase_reg + 2'h1;
      case (state_reg)
        H_IDLE: begin
          phase_reg <= 2'h0;
          if (pend_wr_reg || pend_rd_reg) begin
            state_reg <= H_START; // RL3
            seq_reg <= SEQ_ADDR;
            dc_reg <= pend_dc_reg;
            nack_reg <= 1'b0;
            tx_reg <= {target_reg, ~pend_wr_reg};
          end
        end
        H_START: begin
          if (phase_reg == 2'h0) begin
            sda_oe_n_reg <= 1'b0;
          end else begin
            scl_oe_n_reg <= 1'b0;
            phase_reg <= 2'h0;
            bit_cnt_reg <= 3'h0;
            state_reg <= H_BITS;
          end
        end
        H_BITS: begin
          case (phase_reg)
            2'h0: sda_oe_n_reg <= (seq_reg == SEQ_RX) | tx_reg[7];
            2'h1: scl_oe_n_reg <= 1'b1;
            2'h2: rx_reg <= {rx_reg[6:0], link.sda}; // RL18
            default: begin
              scl_oe_n_reg <= 1'b0;
              tx_reg <= {tx_reg[6:0], 1'b1};
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
              if (bit_cnt_reg == 3'h7) begin
                state_reg <= H_ACK;
              end
            end
          endcase
        end
        H_ACK: begin
          case (phase_reg)
            2'h0: sda_oe_n_reg <= 1'b1;
            2'h1: scl_oe_n_reg <= 1'b1;
            2'h2: nack_reg <= (seq_reg != SEQ_RX) & link.sda;
            default: begin
              scl_oe_n_reg <= 1'b0;
              if (nack_reg || seq_reg == SEQ_RX) begin
                state_reg <= H_STOP;
              end else if (seq_reg == SEQ_ADDR) begin
                state_reg <= H_BITS;
                if (tx_reg == 8'hFF && rx_reg[0]) begin
                  seq_reg <= SEQ_RX;
                end else begin
                  seq_reg <= SEQ_CTRL;
                  tx_reg <= {1'b0, dc_reg, 6'h00}; // RL4 RL16
                end
              end else if (fifo_out_valid) begin
                state_reg <= H_BITS;
                seq_reg <= SEQ_DATA;
                tx_reg <= fifo_out_data;
              end else begin
                state_reg <= H_STOP;
              end
            end
          endcase
        end
        H_STOP: begin
          case (phase_reg)
            2'h0: sda_oe_n_reg <= 1'b0;
            2'h1: scl_oe_n_reg <= 1'b1;
            2'h2: sda_oe_n_reg <= 1'b1; // RL9
            default: state_reg <= H_IDLE;
          endcase
        end
        default: state_reg <= H_IDLE;
      endcase
    end
  end

  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign link.scl_o = 1'b0;
  assign link.scl_oe_n = scl_oe_n_reg;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe_n = sda_oe_n_reg;
  assign link.chip_select_n = cs_n_reg;
endmodule : lcd_host

// *** verification/lcd_link_monitor.sv ***
`timescale 1ns/1ps
module lcd_link_monitor (
  input wire logic clk, // System clock
  input wire logic reset, // Synchronous reset
  input wire logic scl, // Resolved clock line
  input wire logic sda, // Resolved data line
  input wire logic dev_sda_oe_n, // Device pulls data low
  input wire logic chip_select_n // Select from host
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Both lines released once reset ends
  AST_RESET_IDLE: assert property ($fell(reset) |-> scl && sda && dev_sda_oe_n)
    else $error("lines not idle after reset");
  AST_SELECT_LOW: assert property (!chip_select_n)
    else $error("select not low");
  // Device moves data only while clock is low, so it never fakes START or STOP
  AST_DEV_EDGE_LOW: assert property ($changed(dev_sda_oe_n) |-> !scl)
    else $error("device data edge while clock high");
  AST_ACK_HOLD: assert property ($fell(dev_sda_oe_n) |=> !dev_sda_oe_n [*8])
    else $error("acknowledge too short");
  AST_ACK_OVER_HIGH: assert property ($fell(dev_sda_oe_n) |->
    !dev_sda_oe_n throughout (##[1:60] $rose(scl)))
    else $error("acknowledge not held over clock high");
  AST_START_FREE: assert property (scl && $past(scl) && $fell(sda) |-> dev_sda_oe_n)
    else $error("device drives at start");
  AST_STOP_FREE: assert property (scl && $rose(sda) |-> dev_sda_oe_n && $past(scl))
    else $error("bad stop");
  AST_SCL_LOW_MIN: assert property ($fell(scl) |=> !scl [*8])
    else $error("clock low too short");
  // Main scenarios reached
  COV_ACK: cover property ($fell(dev_sda_oe_n));
  COV_START: cover property (scl && $fell(sda));
  COV_STOP: cover property (scl && $rose(sda));
endmodule : lcd_link_monitor

// *** verification/tb_lcd_i2c_slave_cmd_data_port.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) \
  tests_run++; \
  if ((e) !== (g)) begin \
    num_errors++; \
    $display("Error %s expected %h seen %h", n, e, g); \
  end
module tb_lcd_i2c_slave_cmd_data_port;
  import lcd_pkg::*;
  logic clk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic strap_lo = 1'b0, strap_hi = 1'b0, avs_waitrequest, busy_indication;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q, exp_q[$], got_q[$];
  logic [7:0] settings, disp_rd_data, data [32];
  logic [6:0] addr_counter, disp_rd_addr = 7'h00;
  string name_q[$];
  int num_errors = 0, tests_run = 0;
  lcd_link_if link ();
  lcd_host i_lcd_host (.clk(clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(link.host));
  lcd_dev i_lcd_dev (.clk(clk), .reset(reset), .link(link.device), .addr_strap_lo(strap_lo),
    .addr_strap_hi(strap_hi), .busy_indication(busy_indication), .settings(settings),
    .addr_counter(addr_counter), .disp_rd_addr(disp_rd_addr), .disp_rd_data(disp_rd_data));
  lcd_link_monitor i_lcd_link_monitor (.clk(clk), .reset(reset), .scl(link.scl),
    .sda(link.sda), .dev_sda_oe_n(link.dev_sda_oe_n), .chip_select_n(link.chip_select_n));
  initial forever #50 clk = ~clk;
  // Oldest note is popped before comparing, so each value is read once
  initial begin : check
    string n;
    logic [31:0] e, g;
    forever begin
      wait (got_q.size() > 0);
      n = name_q.pop_front();
      e = exp_q.pop_front();
      g = got_q.pop_front();
      `CHK(n, e, g)
    end
  end
  task automatic note(input string n, input logic [31:0] e, input logic [31:0] g);
    name_q.push_back(n);
    exp_q.push_back(e);
    got_q.push_back(g);
  endtask : note
  task automatic results;
    wait (got_q.size() == 0);
    #1;
    $display("Checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  task automatic fail;
    num_errors++;
    results();
  endtask : fail
  // Request held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 9000);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 9000) fail();
  endtask : bus
  // Pending command bits show as busy in status at once; a few cycles pass before polling
  task automatic wait_idle;
    int n;
    n = 0;
    repeat (4) @(posedge clk);
    do begin
      bus(1'b0, REG_STATUS, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 20000);
    if (n >= 20000) fail();
  endtask : wait_idle
  task automatic wait_free;
    int n;
    n = 0;
    while (busy_indication !== 1'b0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    if (n >= 300) fail();
  endtask : wait_free
  task automatic ram(input int a, input logic [7:0] e);
    @(posedge clk);
    disp_rd_addr <= 7'(a);
    repeat (2) @(posedge clk);
    note("ram", 32'(e), 32'(disp_rd_data));
  endtask : ram
  initial begin
    void'($urandom(32'h43E8));
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    note("settings", 32'(SETTINGS_RST), 32'(settings));
    note("pointer", 32'h0, 32'(addr_counter));
    note("busy", 32'h1, 32'(busy_indication));
    wait_free();
    for (int i = 0; i < DISPLAY_DATA_RAM_DEPTH; i++) ram(i, BLANK_CHAR);
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      data[i] = 8'($urandom());
      bus(1'b1, REG_TXDATA, {24'h0, data[i]});
    end
    bus(1'b0, REG_STATUS, 32'h0);
    note("full", 32'h1, 32'(q[3]));
    bus(1'b1, REG_CMD, 32'h5);
    wait_idle();
    note("pointer", 32'h20, 32'(addr_counter));
    for (int i = 0; i < FIFO_DEPTH; i++) ram(i, data[i]);
    // Display on, two lines, decrement, pointer 5, then cursor one step left
    bus(1'b1, REG_TXDATA, 32'h0F);
    bus(1'b1, REG_TXDATA, 32'h38);
    bus(1'b1, REG_TXDATA, 32'h04);
    bus(1'b1, REG_TXDATA, 32'h85);
    bus(1'b1, REG_TXDATA, 32'h10);
    bus(1'b1, REG_CMD, 32'h1);
    wait_idle();
    note("settings", 32'h3E, 32'(settings));
    note("pointer", 32'h4, 32'(addr_counter));
    bus(1'b1, REG_CMD, 32'h2);
    wait_idle();
    note("status", 32'h04, 32'(q[15:8]));
    // Straps move the device away from the target address
    strap_lo <= 1'b1;
    strap_hi <= 1'b1;
    bus(1'b1, REG_CMD, 32'h2);
    wait_idle();
    note("nack", 32'h1, 32'(q[1]));
    bus(1'b1, REG_TARGET, 32'h3F);
    bus(1'b1, REG_TXDATA, 32'h01);
    bus(1'b1, REG_CMD, 32'h1);
    wait_idle();
    wait_free();
    note("pointer", 32'h0, 32'(addr_counter));
    note("settings", 32'hBE, 32'(settings));
    ram(3, BLANK_CHAR);
    results();
  end
endmodule : tb_lcd_i2c_slave_cmd_data_port
